// [rtl/ehsp_pkg.sv]
/*
 holds shared constants of the serial command port.
 assumes both ends run on core_clk at 200 MHz with a synchronous active-low reset.
*/
package ehsp_pkg;
   localparam int EHSP_BYTE_W = 8;
   localparam int EHSP_CNT_W = 4;
   localparam logic [3:0] EHSP_LAST_BIT = 4'h7;
   localparam logic [3:0] EHSP_FLAG_BIT = 4'h8;
   localparam logic [3:0] EHSP_CNT_ZERO = 4'h0;
   localparam logic [3:0] EHSP_CNT_ONE = 4'h1;
   localparam logic [7:0] EHSP_BYTE_ZERO = 8'h00;
   localparam int EHSP_CLK_MHZ = 200;
   localparam int EHSP_SCL_HALF_NS = 250;
   localparam int EHSP_SCL_HALF_CYC = (EHSP_SCL_HALF_NS * EHSP_CLK_MHZ + 999) / 1000;
   localparam int EHSP_DIV_W = 8;
   localparam int EHSP_SYNC_W = 3;
   localparam logic [2:0] EHSP_SYNC_INIT = 3'h0;
   localparam logic [2:0] EHSP_SYNC_INIT_HI = 3'h7;
endpackage : ehsp_pkg

// [rtl/ehsp_if.sv]
/*
 holds the pin-level link between host and display port.
 assumes the bench resolves the shared data wire from the two enables.
*/
`timescale 1ns/100ps
interface ehsp_if;
   logic scl;
   logic cs_n;
   logic dc;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_i;
   logic bus_mode_strap;
   modport dev (
      input scl, cs_n, dc, sda_i, bus_mode_strap,
      output sda_dev_o, sda_dev_oe
   );
   modport host (
      input sda_i,
      output scl, cs_n, dc, sda_host_o, sda_host_oe, bus_mode_strap
   );
endinterface : ehsp_if

// [rtl/ehsp_dev.sv]
/*
 holds the display-side serial port: byte receiver and read shifter.
 assumes pins from the host are asynchronous and sampled by core_clk.
*/
// Behaviour
// - strap low four-wire, high nine-bit three-wire
// - four-wire sample on rising edge, msb first
// - host holds dc steady over byte
// - four-wire dc low command, high data
// - traffic only while chip select low
// - four-wire host raises dc before read data
// - read bytes out on falling edges, msb first
// - read bytes until host raises chip select
// - three-wire dc pin tied low
// - three-wire nine bits, flag then byte
// - flag zero command, one data
// - three-wire read: cmd, flag one, data
`timescale 1ns/100ps
module ehsp_dev
   import ehsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   ehsp_if.dev link,
   output logic rx_valid,
   output logic rx_is_data,
   output logic [EHSP_BYTE_W-1:0] rx_byte,
   output logic rd_req,
   output logic [EHSP_BYTE_W-1:0] rd_cmd,
   input wire logic [EHSP_BYTE_W-1:0] rd_data,
   input wire logic rd_is_reg,
   output logic rd_next
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RECV = 4'h2,
      ST_PEND = 4'h4,
      ST_SEND = 4'h8
   } ehsp_dev_st_e;

   // pin order inside the synchroniser bank
   localparam int PIN_N = 5;
   localparam int PIN_SCL = 0;
   localparam int PIN_CS = 1;
   localparam int PIN_SDA = 2;
   localparam int PIN_DC = 3;
   localparam int PIN_STRAP = 4;

   ehsp_dev_st_e st;
   ehsp_dev_st_e next_st;
   logic mode3;
   logic [EHSP_CNT_W-1:0] cnt;
   logic [EHSP_BYTE_W:0] shreg;
   logic [EHSP_BYTE_W-1:0] tx;
   logic sda_o;
   logic sda_oe;
   wire [PIN_N-1:0] pin_raw = {link.bus_mode_strap, link.dc, link.sda_i, link.cs_n, link.scl};
   wire [PIN_N-1:0] pin_now;
   wire [PIN_N-1:0] pin_was;

   // three stages per pin; the last two must agree before a change counts,
   // a cycle of latency traded for rejecting a single-sample glitch
   for (genvar g = 0; g < PIN_N; g++) begin : g_sync
      logic [EHSP_SYNC_W-1:0] stage;
      logic held;
      wire agree = (stage[2] == stage[1]);
      assign pin_now[g] = agree ? stage[1] : held;
      assign pin_was[g] = held;
      always_ff @(posedge core_clk) begin
         if (!rstn) begin
            // select idles high, so its bank starts high: no false frame
            stage <= (g == PIN_CS) ? EHSP_SYNC_INIT_HI : EHSP_SYNC_INIT;
            held <= (g == PIN_CS);
         end else begin
            stage <= {stage[1:0], pin_raw[g]};
            held <= pin_now[g];
         end
      end
   end

   wire scl_now = pin_now[PIN_SCL];
   wire scl_was = pin_was[PIN_SCL];
   wire sda_now = pin_now[PIN_SDA];
   wire dc_now = pin_now[PIN_DC];
   wire sel = ~pin_now[PIN_CS];
   wire rise = sel & scl_now & ~scl_was;
   wire fall = sel & ~scl_now & scl_was;
   wire in_recv = (st == ST_RECV);
   wire in_pend = (st == ST_PEND);
   wire in_send = (st == ST_SEND);
   wire [EHSP_CNT_W-1:0] last = mode3 ? EHSP_FLAG_BIT : EHSP_LAST_BIT;
   wire last_out = (cnt == EHSP_LAST_BIT);
   wire [EHSP_CNT_W-1:0] next_cnt = cnt + EHSP_CNT_ONE;
   wire done = rise & in_recv & (cnt == last);
   wire shift_in = rise & (in_recv | in_pend);
   wire [EHSP_BYTE_W:0] next_shreg = {shreg[EHSP_BYTE_W-1:0], sda_now};
   wire [EHSP_BYTE_W-1:0] got = next_shreg[EHSP_BYTE_W-1:0];
   // three-wire flag sits one place above the byte still shifting in
   wire is_data = mode3 ? shreg[EHSP_BYTE_W-1] : dc_now;
   wire is_rd_cmd = done & ~is_data & rd_is_reg;
   wire flag_one = rise & mode3 & sda_now;
   wire go_read = sel & in_pend & (mode3 ? flag_one : dc_now);
   wire send_fall = fall & in_send;
   // four-wire read has no flag clock, so its first bit leaves at once
   wire early_bit = go_read & ~mode3;
   wire load = go_read | (send_fall & last_out);

   always_comb begin
      next_st = st;
      unique case (st)
         ST_IDLE: next_st = ST_RECV;
         ST_RECV: if (is_rd_cmd) next_st = ST_PEND;
         ST_PEND: begin
            if (go_read) begin
               next_st = ST_SEND;
            end else if (rise) begin
               next_st = ST_RECV;
            end
         end
         ST_SEND: next_st = ST_SEND;
         default: next_st = ST_IDLE;
      endcase
      // a raised select ends any frame, even one cut short
      if (!sel) begin
         next_st = ST_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= ST_IDLE;
         mode3 <= 1'b0;
      end else begin
         st <= next_st;
         // strap only taken between frames so a glitch cannot split a frame
         if (!sel) begin
            mode3 <= pin_now[PIN_STRAP];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cnt <= EHSP_CNT_ZERO;
         shreg <= '0;
      end else if (!sel) begin
         cnt <= EHSP_CNT_ZERO;
      end else if (go_read) begin
         cnt <= early_bit ? EHSP_CNT_ONE : EHSP_CNT_ZERO;
      end else if (shift_in) begin
         shreg <= next_shreg;
         cnt <= done ? EHSP_CNT_ZERO : next_cnt;
      end else if (send_fall) begin
         cnt <= last_out ? EHSP_CNT_ZERO : next_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rx_valid <= 1'b0;
         rx_is_data <= 1'b0;
         rx_byte <= EHSP_BYTE_ZERO;
         rd_req <= 1'b0;
         rd_cmd <= EHSP_BYTE_ZERO;
      end else begin
         rx_valid <= done;
         rd_req <= is_rd_cmd;
         if (done) begin
            rx_is_data <= is_data;
            rx_byte <= got;
         end
         if (is_rd_cmd) begin
            rd_cmd <= got;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tx <= EHSP_BYTE_ZERO;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
         rd_next <= 1'b0;
      end else begin
         rd_next <= load;
         if (!sel) begin
            sda_oe <= 1'b0;
         end else if (early_bit) begin
            sda_oe <= 1'b1;
            sda_o <= rd_data[EHSP_BYTE_W-1];
            tx <= {rd_data[EHSP_BYTE_W-2:0], 1'b0};
         end else if (go_read) begin
            tx <= rd_data;
         end else if (send_fall) begin
            sda_oe <= 1'b1;
            sda_o <= tx[EHSP_BYTE_W-1];
            // next byte is taken as the last bit of this one leaves
            tx <= last_out ? rd_data : {tx[EHSP_BYTE_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         link.sda_dev_o <= 1'b0;
         link.sda_dev_oe <= 1'b0;
      end else begin
         link.sda_dev_o <= sda_o;
         link.sda_dev_oe <= sda_oe & sel;
      end
   end
endmodule : ehsp_dev

// [rtl/ehsp_host.sv]
/*
 holds the host end: makes the serial clock by divider, sends bytes, reads bytes.
 assumes one request at a time; the device answers reads on falling edges.
*/
`timescale 1ns/100ps
module ehsp_host
   import ehsp_pkg::*;
#(
   parameter int HALF_CYC = EHSP_SCL_HALF_CYC
)(
   input wire logic core_clk,
   input wire logic rstn,
   ehsp_if.host link,
   input wire logic mode3_cfg,
   input wire logic req,
   input wire logic req_is_data,
   input wire logic [EHSP_BYTE_W-1:0] req_byte,
   input wire logic [3:0] rd_count,
   output logic busy,
   output logic rd_valid,
   output logic [EHSP_BYTE_W-1:0] rd_byte
);
   typedef enum logic [4:0] {
      EHSP_IDLE = 5'h01, EHSP_SEND = 5'h02, EHSP_FLAG = 5'h04,
      EHSP_RECV = 5'h08, EHSP_END = 5'h10
   } ehsp_st_e;
   ehsp_st_e st;
   logic [EHSP_DIV_W-1:0] div;
   logic [EHSP_BYTE_W:0] sh;
   logic [EHSP_CNT_W-1:0] bits, left;
   logic [2:0] sda_s;
   logic sda_q;
   logic is_rd;
   // read line counts a change only once the last two stages agree
   wire sda_now = (sda_s[2] == sda_s[1]) ? sda_s[1] : sda_q;
   wire tick = (div == EHSP_DIV_W'(HALF_CYC - 1));
   wire [EHSP_CNT_W-1:0] nbits = (mode3_cfg ? EHSP_FLAG_BIT : EHSP_LAST_BIT);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st <= EHSP_IDLE;
         div <= '0;
         sh <= '0;
         bits <= EHSP_CNT_ZERO;
         left <= EHSP_CNT_ZERO;
         is_rd <= 1'b0;
         sda_s <= EHSP_SYNC_INIT;
         sda_q <= 1'b0;
         busy <= 1'b0;
         rd_valid <= 1'b0;
         rd_byte <= EHSP_BYTE_ZERO;
         link.scl <= 1'b0;
         link.cs_n <= 1'b1;
         link.dc <= 1'b0;
         link.sda_host_o <= 1'b0;
         link.sda_host_oe <= 1'b0;
         link.bus_mode_strap <= 1'b0;
      end else begin
         sda_s <= {sda_s[1:0], link.sda_i};
         sda_q <= sda_now;
         rd_valid <= 1'b0;
         link.bus_mode_strap <= mode3_cfg;
         div <= tick ? '0 : div + 1'b1;
         unique case (st)
            EHSP_IDLE: if (req) begin
               st <= EHSP_SEND;
               busy <= 1'b1;
               is_rd <= (rd_count != EHSP_CNT_ZERO);
               left <= rd_count;
               // three-wire frame carries flag first
               sh <= mode3_cfg ? {req_is_data, req_byte} : {req_byte, 1'b0};
               link.dc <= mode3_cfg ? 1'b0 : req_is_data;
               link.cs_n <= 1'b0;
               link.sda_host_oe <= 1'b1;
               link.sda_host_o <= mode3_cfg ? req_is_data : req_byte[EHSP_BYTE_W-1];
               bits <= EHSP_CNT_ZERO;
               div <= '0;
            end
            EHSP_SEND: if (tick) begin
               link.scl <= ~link.scl;
               if (link.scl) begin
                  bits <= bits + 4'h1;
                  sh <= {sh[EHSP_BYTE_W-1:0], 1'b0};
                  link.sda_host_o <= sh[EHSP_BYTE_W-1];
                  if (bits == nbits) begin
                     bits <= EHSP_CNT_ZERO;
                     if (is_rd && mode3_cfg) begin
                        st <= EHSP_FLAG;
                        link.sda_host_o <= 1'b1;
                     end else if (is_rd) begin
                        st <= EHSP_RECV;
                        link.dc <= 1'b1;
                        link.sda_host_oe <= 1'b0;
                     end else st <= EHSP_END;
                  end
               end
            end
            EHSP_FLAG: if (tick) begin
               link.scl <= ~link.scl;
               if (link.scl) begin
                  st <= EHSP_RECV;
                  link.sda_host_oe <= 1'b0;
               end
            end
            EHSP_RECV: if (tick) begin
               link.scl <= ~link.scl;
               if (!link.scl) begin
                  sh <= {sh[EHSP_BYTE_W-1:0], sda_now};
                  bits <= (bits == EHSP_LAST_BIT) ? EHSP_CNT_ZERO : bits + 4'h1;
                  if (bits == EHSP_LAST_BIT) begin
                     rd_valid <= 1'b1;
                     rd_byte <= {sh[EHSP_BYTE_W-2:0], sda_now};
                     left <= left - 4'h1;
                     if (left == 4'h1) st <= EHSP_END;
                  end
               end
            end
            EHSP_END: if (tick) begin
               st <= EHSP_IDLE;
               busy <= 1'b0;
               link.cs_n <= 1'b1;
               link.dc <= 1'b0;
               link.sda_host_oe <= 1'b0;
               link.scl <= 1'b0;
            end
         endcase
      end
   end
endmodule : ehsp_host

// [sim/ehsp_chk.sv]
/*
 holds wire-level assertions for the serial command link.
 assumes one core_clk domain and a synchronous active-low rstn.
*/
`timescale 1ns/100ps
module ehsp_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic scl,
   input wire logic cs_n,
   input wire logic dc,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic bus_mode_strap
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_frame_open;
      $fell(cs_n);
   endsequence
   sequence s_quiet_clock;
      !scl [*8];
   endsequence
   a_cs_setup_gap: assert property (s_frame_open |-> s_quiet_clock)
      else $error("clock moved too soon after select");
   // device syncs cs_n, so allow a few cycles before release
   a_idle_release: assert property (cs_n [*8] |-> !sda_dev_oe)
      else $error("device drives data while idle");
   a_dev_not_early: assert property ($rose(sda_dev_oe) |-> !cs_n && (bus_mode_strap || dc))
      else $error("device drove data before read phase");
   a_single_driver: assert property (!(sda_dev_oe && sda_host_oe))
      else $error("both ends drive data");
   a_dc_quiet_edge: assert property (!bus_mode_strap && !cs_n && $changed(dc) |-> !scl)
      else $error("dc moved while clock high");
   a_dc_tied_low: assert property (bus_mode_strap |-> !dc)
      else $error("dc not low in three-wire mode");
   a_host_hold: assert property (scl && $past(scl) && sda_host_oe && $past(sda_host_oe)
      |-> $stable(sda_host_o))
      else $error("host data moved while clock high");
   a_dev_launch: assert property (sda_dev_oe && $past(sda_dev_oe) && $changed(sda_dev_o)
      |-> !scl)
      else $error("read bit launched while clock high");
endmodule : ehsp_chk

// [sim/ehsp_tb_top.sv]
/*
 holds the bench joining host and display ends over one link.
 assumes a 200 MHz core_clk and a short serial clock divider.
*/
`timescale 1ns/100ps
module ehsp_tb_top
   import ehsp_pkg::*;
;
   logic core_clk = 0, rstn = 0, m3 = 0, req = 0, isd = 0, is_reg = 0;
   logic rx_valid, rx_is_data, rd_req, rd_next, busy, rd_valid;
   logic [7:0] rx_byte, rd_cmd, rd_byte, rbyte = 8'h00;
   logic [7:0] tab [8];
   logic [3:0] cnt = 4'h0;
   int idx = 0, miscompares = 0, cmp_count = 0;
   logic [8:0] rxq [$], rdq [$];
   ehsp_if lnk ();
   always #2.5 core_clk = ~core_clk;
   // pull-up when nobody drives
   assign lnk.sda_i = lnk.sda_dev_oe ? lnk.sda_dev_o : lnk.sda_host_oe ? lnk.sda_host_o : 1'b1;
   ehsp_host #(.HALF_CYC(10)) ehsp_host_i (.core_clk(core_clk), .rstn(rstn), .link(lnk.host),
      .mode3_cfg(m3), .req(req), .req_is_data(isd), .req_byte(rbyte), .rd_count(cnt),
      .busy(busy), .rd_valid(rd_valid), .rd_byte(rd_byte));
   ehsp_dev ehsp_dev_i (.core_clk(core_clk), .rstn(rstn), .link(lnk.dev), .rx_valid(rx_valid),
      .rx_is_data(rx_is_data), .rx_byte(rx_byte), .rd_req(rd_req), .rd_cmd(rd_cmd),
      .rd_data(tab[idx[2:0]]), .rd_is_reg(is_reg), .rd_next(rd_next));
   ehsp_chk ehsp_chk_i (.core_clk(core_clk), .rstn(rstn), .scl(lnk.scl), .cs_n(lnk.cs_n),
      .dc(lnk.dc), .sda_host_o(lnk.sda_host_o), .sda_host_oe(lnk.sda_host_oe),
      .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe),
      .bus_mode_strap(lnk.bus_mode_strap));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      if (rd_next) idx <= idx + 1;
      if (rx_valid) chk({rx_is_data, rx_byte}, rxq.size() ? rxq.pop_front() : 9'bx);
      if (rd_valid) chk({1'b0, rd_byte}, rdq.size() ? rdq.pop_front() : 9'bx);
      if (rd_req) chk({1'b0, rd_cmd}, {1'b0, rbyte});
   end
   // strap set early: the device only samples it between frames
   task automatic xfer(input logic mode3, input logic data, input logic [3:0] n);
      int t = 0;
      @(posedge core_clk);
      #1 m3 = mode3;
      foreach (tab[i]) tab[i] = 8'($urandom);
      repeat (4) @(posedge core_clk);
      #1 isd = data;
      rbyte = 8'($urandom);
      cnt = n;
      is_reg = (n != 4'h0);
      idx = 0;
      req = 1;
      rxq.push_back({data, rbyte});
      for (int i = 0; i < n; i++) rdq.push_back({1'b0, tab[i[2:0]]});
      @(posedge core_clk);
      #1 req = 0;
      while (busy !== 1'b0 && t < 20000) begin
         @(posedge core_clk);
         t++;
      end
      if (t == 20000) begin
         miscompares++;
         wrap_up();
      end
   endtask : xfer
   initial begin
      void'($urandom(32'h52f2485b));
      foreach (tab[i]) tab[i] = 8'h00;
      repeat (4) @(posedge core_clk);
      #1 rstn = 1;
      // writes in both modes, then reads of one and eight bytes
      for (int k = 0; k < 8; k++) xfer(k[1], k[0], 4'h0);
      for (int k = 0; k < 4; k++) xfer(k[0], 1'b0, k[1] ? 4'h8 : 4'h1);
      repeat (20) @(posedge core_clk);
      chk(9'(rxq.size()), 9'h000);
      chk(9'(rdq.size()), 9'h000);
      wrap_up();
   end
endmodule : ehsp_tb_top
